//--- rtl/pbrs_defines.vh
`ifndef PBRS_DEFINES_VH
`define PBRS_DEFINES_VH

// ----------------------------------------------------------------------
// clock rate
// ----------------------------------------------------------------------
`define PBRS_CLK_HZ 20000000
`define PBRS_CYC_PER_MS (`PBRS_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// times in milliseconds
// ----------------------------------------------------------------------
`define PBRS_DEBOUNCE_MS 10
`define PBRS_RESET_SETUP_MS 10000
`define PBRS_DISCHARGE_MS 200
`define PBRS_DCHG_DELAY_MS 5
`define PBRS_SHIP_ENTRY_MS 15000
`define PBRS_PHASE_HOLD_MAX_MS 1
`define PBRS_TRAIN_WINDOW_MS 100
`define PBRS_SHIP_EXIT_MS 2000

// ----------------------------------------------------------------------
// times in core clock cycles
// ----------------------------------------------------------------------
`define PBRS_DEBOUNCE_CYC (`PBRS_DEBOUNCE_MS * `PBRS_CYC_PER_MS)
`define PBRS_RESET_SETUP_CYC (`PBRS_RESET_SETUP_MS * `PBRS_CYC_PER_MS)
`define PBRS_DISCHARGE_CYC (`PBRS_DISCHARGE_MS * `PBRS_CYC_PER_MS)
`define PBRS_DCHG_DELAY_CYC (`PBRS_DCHG_DELAY_MS * `PBRS_CYC_PER_MS)
`define PBRS_SHIP_ENTRY_CYC (`PBRS_SHIP_ENTRY_MS * `PBRS_CYC_PER_MS)
`define PBRS_PHASE_HOLD_CYC (`PBRS_PHASE_HOLD_MAX_MS * `PBRS_CYC_PER_MS)
`define PBRS_TRAIN_WINDOW_CYC (`PBRS_TRAIN_WINDOW_MS * `PBRS_CYC_PER_MS)
`define PBRS_SHIP_EXIT_CYC (`PBRS_SHIP_EXIT_MS * `PBRS_CYC_PER_MS)

// ----------------------------------------------------------------------
// reset values, pulse count and field sizes
// ----------------------------------------------------------------------
`define PBRS_KEY_IDLE 1'b1
`define PBRS_CHG_IDLE 1'b0
`define PBRS_PULSES_NEEDED 3'h5
`define PBRS_CNT_W 32

`endif

//--- rtl/pbrs_debounce.v
`timescale 1ns/10ps
`include "pbrs_defines.vh"

// level debouncer, input must already be synchronised
module pbrs_debounce #(
	parameter [31:0] STABLE_CYC = `PBRS_DEBOUNCE_CYC,
	parameter RESET_LEVEL = 1'b1
) (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// level in and out
	input wire levelIn,
	output reg levelOut_q
);

	reg [31:0] stableCnt_q;

	// ------------------------------------------------------------------
	// accept a change only after it stood for STABLE_CYC cycles
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stableCnt_q <= 32'h0;
			levelOut_q <= RESET_LEVEL;
		end else if (levelIn == levelOut_q) begin
			stableCnt_q <= 32'h0;
		end else if (stableCnt_q >= STABLE_CYC - 32'h1) begin
			stableCnt_q <= 32'h0;
			levelOut_q <= levelIn;
		end else begin
			stableCnt_q <= stableCnt_q + 32'h1;
		end
	end

endmodule // pbrs_debounce

//--- rtl/pbrs_ctrl.v
`timescale 1ns/10ps
`include "pbrs_defines.vh"

module pbrs_ctrl #(
	parameter [31:0] DEBOUNCE_CYC = `PBRS_DEBOUNCE_CYC,
	parameter [31:0] RESET_SETUP_CYC = `PBRS_RESET_SETUP_CYC,
	parameter [31:0] DISCHARGE_CYC = `PBRS_DISCHARGE_CYC,
	parameter [31:0] DCHG_DELAY_CYC = `PBRS_DCHG_DELAY_CYC,
	parameter [31:0] SHIP_ENTRY_CYC = `PBRS_SHIP_ENTRY_CYC,
	parameter [31:0] PHASE_HOLD_CYC = `PBRS_PHASE_HOLD_CYC,
	parameter [31:0] TRAIN_WINDOW_CYC = `PBRS_TRAIN_WINDOW_CYC,
	parameter [31:0] SHIP_EXIT_CYC = `PBRS_SHIP_EXIT_CYC
) (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// push-button keys, low while pressed
	input wire keyInputA,
	input wire keyInputB,
	// ship request pulse train from host processor
	input wire shipRequest,
	// charger sense, high while a charger is present
	input wire chargerSense,
	// battery switch and reset outputs
	output reg batterySwitchGateOut_q,
	output reg hostResetOut_n_q,
	// discharge outputs, low while pulling capacitors down
	output reg dischargeOutA_q,
	output reg dischargeOutB_q,
	// status
	output reg shipModeActive_q,
	output reg shipExitCharger_q
);

	// ------------------------------------------------------------------
	// states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_QUAL = 3'h1;
	localparam [2:0] ST_PRE = 3'h2;
	localparam [2:0] ST_DISCH = 3'h3;
	localparam [2:0] ST_POST = 3'h4;
	localparam [2:0] ST_SHIP_WAIT = 3'h5;
	localparam [2:0] ST_SHIP = 3'h6;

	// ------------------------------------------------------------------
	// saturating increment of a cycle counter
	// ------------------------------------------------------------------
	function [31:0] pbrsInc;
		input [31:0] v;
		begin
			pbrsInc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
		end
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	reg keyAMeta_q;
	reg keyASync_q;
	reg keyBMeta_q;
	reg keyBSync_q;
	reg chgMeta_q;
	reg chgSync_q;
	reg reqMeta_q;
	reg reqSync_q;
	wire keyADeb;
	wire keyBDeb;
	wire chgDeb;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [31:0] cnt_q;
	reg [31:0] cnt_d;
	reg armed_q;
	reg armed_d;
	reg exitCharger_d;
	reg reqPrev_q;
	reg [31:0] phase_q;
	reg [31:0] win_q;
	reg [2:0] pulses_q;
	reg trainActive_q;
	reg trainDone_q;
	wire bothLow;
	wire trainEnable;
	wire reqEdge;
	reg [31:0] settleCnt_q;
	wire keysSettled;

	// ------------------------------------------------------------------
	// two-flop synchronisers on every pin input
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			keyAMeta_q <= `PBRS_KEY_IDLE;
			keyASync_q <= `PBRS_KEY_IDLE;
			keyBMeta_q <= `PBRS_KEY_IDLE;
			keyBSync_q <= `PBRS_KEY_IDLE;
			chgMeta_q <= `PBRS_CHG_IDLE;
			chgSync_q <= `PBRS_CHG_IDLE;
			reqMeta_q <= 1'b0;
			reqSync_q <= 1'b0;
		end else begin
			keyAMeta_q <= keyInputA;
			keyASync_q <= keyAMeta_q;
			keyBMeta_q <= keyInputB;
			keyBSync_q <= keyBMeta_q;
			chgMeta_q <= chargerSense;
			chgSync_q <= chgMeta_q;
			reqMeta_q <= shipRequest;
			reqSync_q <= reqMeta_q;
		end
	end

	// ------------------------------------------------------------------
	// debouncers for both keys and charger sense
	// ------------------------------------------------------------------
	pbrs_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC),
		.RESET_LEVEL(`PBRS_KEY_IDLE)
	) uDebKeyA (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.levelIn(keyASync_q),
		.levelOut_q(keyADeb)
	);

	pbrs_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC),
		.RESET_LEVEL(`PBRS_KEY_IDLE)
	) uDebKeyB (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.levelIn(keyBSync_q),
		.levelOut_q(keyBDeb)
	);

	pbrs_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC),
		.RESET_LEVEL(`PBRS_CHG_IDLE)
	) uDebChg (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.levelIn(chgSync_q),
		.levelOut_q(chgDeb)
	);

	// both debounced keys pressed
	assign bothLow = !keyADeb && !keyBDeb;

	// pulse decoding only while idle and keys not both pressed
	assign trainEnable = (state_q == ST_IDLE) && !bothLow;
	assign reqEdge = reqSync_q != reqPrev_q;

	// debouncers start at released, so arming waits until pins were seen
	assign keysSettled = settleCnt_q >= DEBOUNCE_CYC + 32'h3;

	// ------------------------------------------------------------------
	// ship request pulse train decoder
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reqPrev_q <= 1'b0;
			phase_q <= 32'h0;
			win_q <= 32'h0;
			pulses_q <= 3'h0;
			trainActive_q <= 1'b0;
			trainDone_q <= 1'b0;
		end else begin
			reqPrev_q <= reqSync_q;
			trainDone_q <= 1'b0;
			phase_q <= reqEdge ? 32'h0 : pbrsInc(phase_q);
			if (!trainEnable) begin
				trainActive_q <= 1'b0;
				pulses_q <= 3'h0;
				win_q <= 32'h0;
			end else if (trainActive_q &&
				win_q >= TRAIN_WINDOW_CYC - 32'h1) begin
				trainActive_q <= 1'b0;
				pulses_q <= 3'h0;
				win_q <= 32'h0;
			end else if (reqEdge && reqSync_q) begin
				// rising edge: short low phase restarts the train
				if (!trainActive_q || phase_q < PHASE_HOLD_CYC) begin
					trainActive_q <= 1'b1;
					pulses_q <= 3'h0;
					win_q <= 32'h0;
				end else begin
					win_q <= pbrsInc(win_q);
				end
			end else if (reqEdge && trainActive_q) begin
				// falling edge closes a high phase
				if (phase_q < PHASE_HOLD_CYC) begin
					trainActive_q <= 1'b0;
					pulses_q <= 3'h0;
					win_q <= 32'h0;
				end else if (pulses_q == `PBRS_PULSES_NEEDED - 3'h1) begin
					trainDone_q <= 1'b1;
					trainActive_q <= 1'b0;
					pulses_q <= 3'h0;
					win_q <= 32'h0;
				end else begin
					pulses_q <= pulses_q + 3'h1;
					win_q <= pbrsInc(win_q);
				end
			end else if (trainActive_q) begin
				win_q <= pbrsInc(win_q);
			end
		end
	end

	// ------------------------------------------------------------------
	// next state, counter and arming
	// ------------------------------------------------------------------
	always @* begin
		state_d = state_q;
		cnt_d = pbrsInc(cnt_q);
		exitCharger_d = shipExitCharger_q;
		// a released key re-arms reset qualification
		armed_d = armed_q || (keysSettled && (keyADeb || keyBDeb));
		case (state_q)
			ST_IDLE: begin
				cnt_d = 32'h0;
				if (bothLow && armed_q) begin
					state_d = ST_QUAL;
				end else if (trainDone_q) begin
					state_d = ST_SHIP_WAIT;
				end
			end
			ST_QUAL: begin
				if (!bothLow) begin
					state_d = ST_IDLE;
				end else if (cnt_q >= RESET_SETUP_CYC - 32'h1) begin
					state_d = ST_PRE;
					cnt_d = 32'h0;
				end
			end
			ST_PRE: begin
				// no input is looked at until release
				if (cnt_q >= DCHG_DELAY_CYC - 32'h1) begin
					state_d = ST_DISCH;
					cnt_d = 32'h0;
				end
			end
			ST_DISCH: begin
				if (cnt_q >= DISCHARGE_CYC - 32'h1) begin
					state_d = ST_POST;
					cnt_d = 32'h0;
				end
			end
			ST_POST: begin
				armed_d = 1'b0;
				if (cnt_q >= DCHG_DELAY_CYC - 32'h1) begin
					state_d = ST_IDLE;
					cnt_d = 32'h0;
				end
			end
			ST_SHIP_WAIT: begin
				// keys and charger both ignored here
				armed_d = 1'b0;
				if (cnt_q >= SHIP_ENTRY_CYC - 32'h1) begin
					state_d = ST_SHIP;
					cnt_d = 32'h0;
				end
			end
			ST_SHIP: begin
				armed_d = 1'b0;
				if (chgDeb) begin
					state_d = ST_IDLE;
					exitCharger_d = 1'b1;
					cnt_d = 32'h0;
				end else if (keyADeb) begin
					cnt_d = 32'h0;
				end else if (cnt_q >= SHIP_EXIT_CYC - 32'h1) begin
					state_d = ST_IDLE;
					exitCharger_d = 1'b0;
					cnt_d = 32'h0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d = 32'h0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// state registers, cleared at power-on
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 32'h0;
			armed_q <= 1'b0;
			shipExitCharger_q <= 1'b0;
			settleCnt_q <= 32'h0;
		end else begin
			settleCnt_q <= keysSettled ? settleCnt_q : settleCnt_q + 32'h1;
			state_q <= state_d;
			cnt_q <= cnt_d;
			armed_q <= armed_d;
			shipExitCharger_q <= exitCharger_d;
		end
	end

	// ------------------------------------------------------------------
	// registered outputs decoded from the next state
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			batterySwitchGateOut_q <= 1'b0;
			hostResetOut_n_q <= 1'b1;
			dischargeOutA_q <= 1'b1;
			dischargeOutB_q <= 1'b1;
			shipModeActive_q <= 1'b0;
		end else begin
			// gate high through whole reset and in ship mode
			batterySwitchGateOut_q <= (state_d == ST_PRE) ||
				(state_d == ST_DISCH) || (state_d == ST_POST) ||
				(state_d == ST_SHIP);
			hostResetOut_n_q <= !((state_d == ST_PRE) ||
				(state_d == ST_DISCH) || (state_d == ST_POST));
			// discharge only inside the reset discharge period
			dischargeOutA_q <= state_d != ST_DISCH;
			dischargeOutB_q <= state_d != ST_DISCH;
			shipModeActive_q <= state_d == ST_SHIP;
		end
	end

endmodule // pbrs_ctrl

//--- bench/pbrs_ctrl_props.sv
`timescale 1ns/10ps
// ---------------------------------------------
// port checker for the reset and ship controller
// ---------------------------------------------
module pbrs_ctrl_props #(
	parameter [31:0] RESET_SETUP_CYC = 32'h28,
	parameter [31:0] SHIP_EXIT_CYC = 32'h1E
) (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// pins in
	input wire keyInputA,
	input wire keyInputB,
	input wire shipRequest,
	input wire chargerSense,
	// pins out
	input wire batterySwitchGateOut_q,
	input wire hostResetOut_n_q,
	input wire dischargeOutA_q,
	input wire dischargeOutB_q,
	input wire shipModeActive_q,
	input wire shipExitCharger_q
);
	logic [7:0] bothLowCnt_q;
	logic [7:0] keyALowCnt_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// saturating run lengths of low key pins
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bothLowCnt_q <= 8'h00;
			keyALowCnt_q <= 8'h00;
		end else begin
			bothLowCnt_q <= (keyInputA | keyInputB) ? 8'h00 :
				bothLowCnt_q + {7'h00, bothLowCnt_q != 8'hFF};
			keyALowCnt_q <= keyInputA ? 8'h00 :
				keyALowCnt_q + {7'h00, keyALowCnt_q != 8'hFF};
		end
	end

	reset_qual_a: assert property (
		$fell(hostResetOut_n_q) |-> {24'h0, bothLowCnt_q} >= RESET_SETUP_CYC)
		else $error("reset began before keys were low long enough");
	gate_first_a: assert property (
		$fell(dischargeOutA_q) |-> batterySwitchGateOut_q && !hostResetOut_n_q)
		else $error("discharge began without gate high first");
	dchg_pair_a: assert property (dischargeOutA_q == dischargeOutB_q)
		else $error("discharge outputs differ");
	dchg_delay_a: assert property (
		$fell(hostResetOut_n_q) |-> dischargeOutA_q[*4] ##[1:3] !dischargeOutA_q)
		else $error("discharge delay before discharge wrong");
	dchg_len_a: assert property (
		$fell(dischargeOutA_q) |->
		!dischargeOutA_q[*8] ##[10:14] $rose(dischargeOutA_q))
		else $error("discharge period length wrong");
	reset_release_a: assert property (
		$rose(dischargeOutA_q) |-> (batterySwitchGateOut_q &&
		!hostResetOut_n_q)[*4] ##[1:3] (!batterySwitchGateOut_q && hostResetOut_n_q))
		else $error("reset release after discharge wrong");
	ship_outputs_a: assert property (
		shipModeActive_q |->
		batterySwitchGateOut_q && hostResetOut_n_q && dischargeOutA_q)
		else $error("ship mode outputs wrong");
	charger_exit_a: assert property (
		shipModeActive_q && chargerSense |-> ##[1:8] !shipModeActive_q)
		else $error("charger did not end ship mode");
	exit_gate_a: assert property (
		$fell(shipModeActive_q) |-> !batterySwitchGateOut_q && hostResetOut_n_q)
		else $error("gate not released on ship exit");
	key_exit_a: assert property (
		$fell(shipModeActive_q) && !shipExitCharger_q |->
		{24'h0, keyALowCnt_q} >= SHIP_EXIT_CYC)
		else $error("key exit before hold time");
endmodule // pbrs_ctrl_props

bind pbrs_ctrl pbrs_ctrl_props #(
	.RESET_SETUP_CYC(RESET_SETUP_CYC),
	.SHIP_EXIT_CYC(SHIP_EXIT_CYC)
) u_props (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.keyInputA(keyInputA),
	.keyInputB(keyInputB),
	.shipRequest(shipRequest),
	.chargerSense(chargerSense),
	.batterySwitchGateOut_q(batterySwitchGateOut_q),
	.hostResetOut_n_q(hostResetOut_n_q),
	.dischargeOutA_q(dischargeOutA_q),
	.dischargeOutB_q(dischargeOutB_q),
	.shipModeActive_q(shipModeActive_q),
	.shipExitCharger_q(shipExitCharger_q)
);

//--- bench/pbrs_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// host processor: ship request pulse source
// ---------------------------------------------
module pbrs_host_model #(
	parameter int PHASE_CYC = 10
) (
	// clock
	input wire core_clk,
	// ship request pin, idle low
	output logic shipRequest
);
	initial shipRequest = 1'b0;

	// pulses with both phases above the hold limit
	task automatic send_train(input int pulses);
		for (int i = 0; i < pulses; i++) begin
			@(posedge core_clk);
			shipRequest <= 1'b1;
			repeat (PHASE_CYC) @(posedge core_clk);
			shipRequest <= 1'b0;
			repeat (PHASE_CYC - 1) @(posedge core_clk);
		end
	endtask
endmodule // pbrs_host_model

//--- bench/pbrs_ctrl_tb_top.sv
`timescale 1ns/10ps
module pbrs_ctrl_tb_top;
	logic core_clk, reset_n, keyInputA, keyInputB, chargerSense;
	wire shipRequest, batterySwitchGateOut_q, hostResetOut_n_q;
	wire dischargeOutA_q, dischargeOutB_q, shipModeActive_q, shipExitCharger_q;
	int failures, compares;

	// clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// shortened counts so every scenario fits a short run
	localparam logic [31:0] SIM_DEBOUNCE = 32'h4;
	localparam logic [31:0] SIM_SETUP = 32'h28;
	localparam logic [31:0] SIM_DISCHARGE = 32'h14;
	localparam logic [31:0] SIM_DCHG_DELAY = 32'h5;
	localparam logic [31:0] SIM_ENTRY = 32'h3C;
	localparam logic [31:0] SIM_PHASE = 32'h8;
	localparam logic [31:0] SIM_WINDOW = 32'hC8;
	localparam logic [31:0] SIM_EXIT = 32'h1E;

	// design with shortened counts
	pbrs_ctrl #(.DEBOUNCE_CYC(SIM_DEBOUNCE), .RESET_SETUP_CYC(SIM_SETUP),
		.DISCHARGE_CYC(SIM_DISCHARGE), .DCHG_DELAY_CYC(SIM_DCHG_DELAY),
		.SHIP_ENTRY_CYC(SIM_ENTRY), .PHASE_HOLD_CYC(SIM_PHASE),
		.TRAIN_WINDOW_CYC(SIM_WINDOW), .SHIP_EXIT_CYC(SIM_EXIT)) u_dut (
		.core_clk(core_clk), .reset_n(reset_n),
		.keyInputA(keyInputA), .keyInputB(keyInputB),
		.shipRequest(shipRequest), .chargerSense(chargerSense),
		.batterySwitchGateOut_q(batterySwitchGateOut_q),
		.hostResetOut_n_q(hostResetOut_n_q),
		.dischargeOutA_q(dischargeOutA_q), .dischargeOutB_q(dischargeOutB_q),
		.shipModeActive_q(shipModeActive_q),
		.shipExitCharger_q(shipExitCharger_q));

	pbrs_host_model u_host (
		.core_clk(core_clk), .shipRequest(shipRequest));

	// gate, host reset, discharge a, discharge b
	function automatic logic [3:0] outs();
		return {batterySwitchGateOut_q, hostResetOut_n_q,
			dischargeOutA_q, dischargeOutB_q};
	endfunction

	task automatic chk(input logic [3:0] got, input logic [3:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: %s", $time, what);
		end
	endtask

	// waits n edges, then lets the updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// outputs must hold exp on every one of n edges
	task automatic watch(input int n, input logic [3:0] exp,
		input string what);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			cyc(1);
			if (outs() !== exp)
				bad = 1'b1;
		end
		chk({3'h0, bad}, 4'h0, what);
	endtask

	task automatic keys(input logic a, input logic b);
		@(posedge core_clk);
		keyInputA <= a;
		keyInputB <= b;
	endtask

	task automatic t_power_on;
		chk(outs(), 4'h7, "outputs after power-on");
		chk({3'h0, shipModeActive_q}, 4'h0, "ship after power-on");
		watch(100, 4'h7, "reset with keys low at power-on");
		keys(1'b1, 1'b1);
		cyc(10);
		$display("test power_on done");
	endtask

	task automatic t_reset;
		int n;
		keys(1'b0, 1'b0);
		n = 0;
		while (hostResetOut_n_q !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
		chk({3'h0, n >= 40 && n < 60}, 4'h1, "reset start time");
		chk(outs(), 4'hB, "gate before discharge");
		cyc(12);
		chk(outs(), 4'h8, "discharge phase");
		cyc(30);
		chk(outs(), 4'h7, "release after reset");
		watch(150, 4'h7, "second reset while keys held");
		keys(1'b1, 1'b1);
		cyc(10);
		$display("test reset done");
	endtask

	task automatic t_short;
		keys(1'b0, 1'b0);
		watch(30, 4'h7, "reset during short press");
		keys(1'b1, 1'b1);
		watch(100, 4'h7, "reset after short press");
		$display("test short press done");
	endtask

	task automatic t_ship_short;
		u_host.send_train(4);
		watch(250, 4'h7, "outputs after 4 pulses");
		chk({3'h0, shipModeActive_q}, 4'h0, "ship after 4 pulses");
		$display("test short train done");
	endtask

	task automatic t_priority;
		keys(1'b0, 1'b0);
		fork
			u_host.send_train(5);
			begin
				cyc(60);
				chk(outs(), 4'h8, "reset stalled by ship pulses");
			end
		join
		cyc(100);
		chk({3'h0, shipModeActive_q}, 4'h0, "ship during key hold");
		chk(outs(), 4'h7, "outputs after keyed reset");
		keys(1'b1, 1'b1);
		cyc(10);
		$display("test priority done");
	endtask

	task automatic t_ship_key;
		u_host.send_train(5);
		keys(1'b0, 1'b0);
		watch(40, 4'h7, "reset during entry delay");
		chk({3'h0, shipModeActive_q}, 4'h0, "early ship entry");
		keys(1'b1, 1'b1);
		cyc(30);
		chk({3'h0, shipModeActive_q}, 4'h1, "ship entry");
		chk(outs(), 4'hF, "ship mode outputs");
		keys(1'b0, 1'b0);
		cyc(25);
		chk({3'h0, shipModeActive_q}, 4'h1, "early key exit");
		cyc(20);
		chk({2'h0, shipModeActive_q, shipExitCharger_q}, 4'h0,
			"key exit");
		chk(outs(), 4'h7, "outputs after key exit");
		watch(80, 4'h7, "reset after ship exit");
		keys(1'b1, 1'b1);
		cyc(10);
		$display("test ship key exit done");
	endtask

	task automatic t_ship_chg;
		logic seen;
		seen = 1'b0;
		u_host.send_train(5);
		@(posedge core_clk);
		chargerSense <= 1'b1;
		repeat (100) begin
			cyc(1);
			if (shipModeActive_q === 1'b1)
				seen = 1'b1;
		end
		chk({3'h0, seen}, 4'h1, "ship entry with charger");
		chk({2'h0, shipModeActive_q, shipExitCharger_q}, 4'h1,
			"charger exit");
		chk(outs(), 4'h7, "outputs after charger exit");
		@(posedge core_clk);
		chargerSense <= 1'b0;
		cyc(10);
		$display("test ship charger exit done");
	endtask

	// charger rising while key A is held must end ship mode early
	task automatic t_ship_both;
		int n;
		u_host.send_train(5);
		n = 0;
		while (shipModeActive_q !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk({3'h0, shipModeActive_q}, 4'h1, "ship before key hold");
		keys(1'b0, 1'b1);
		cyc(10);
		@(posedge core_clk);
		chargerSense <= 1'b1;
		cyc(12);
		chk({2'h0, shipModeActive_q, shipExitCharger_q}, 4'h1,
			"charger during key hold");
		chk(outs(), 4'h7, "outputs after charger priority");
		@(posedge core_clk);
		chargerSense <= 1'b0;
		keys(1'b1, 1'b1);
		cyc(10);
		$display("test ship key and charger done");
	endtask

	task automatic end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial begin
		reset_n = 1'b0;
		keyInputA = 1'b0;
		keyInputB = 1'b0;
		chargerSense = 1'b0;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		cyc(1);
		t_power_on();
		t_reset();
		t_reset();
		t_short();
		t_ship_short();
		t_priority();
		t_ship_key();
		t_ship_chg();
		t_ship_both();
		end_of_test();
	end

	// watchdog
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		$display("ERROR %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule // pbrs_ctrl_tb_top
